// File: src/pifr_regs.vh
`ifndef PIFR_REGS_VH
`define PIFR_REGS_VH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define PIFR_IDX_W           12
`define PIFR_IDX_PERIOD      12'he38
`define PIFR_IDX_GATE        12'he39
`define PIFR_IDX_CAPCOMP     12'he3a
`define PIFR_IDX_SYSTEM      12'he3b

// ****************************************************************
// Implemented bits of each register
// ****************************************************************
`define PIFR_MASK_PERIOD     8'h01
`define PIFR_MASK_GATE       8'h0f
`define PIFR_MASK_CAPCOMP    8'h1f
`define PIFR_MASK_SYSTEM     8'he1

// ****************************************************************
// Reset values
// ****************************************************************
`define PIFR_RST_PERIOD      8'h00
`define PIFR_RST_GATE        8'h00
`define PIFR_RST_CAPCOMP     8'h00
`define PIFR_RST_SYSTEM      8'h00

// ****************************************************************
// Field positions
// ****************************************************************
`define PIFR_TMR1_PERIOD_BIT 0
`define PIFR_GATE_TMR1_BIT   0
`define PIFR_GATE_TMR3_BIT   1
`define PIFR_GATE_TMR5_BIT   2
`define PIFR_GATE_TMR7_BIT   3
`define PIFR_SYS_WAVE_BIT    0
`define PIFR_SYS_NVM_BIT     5
`define PIFR_SYS_CHECK_BIT   6
`define PIFR_SYS_SCAN_BIT    7

// ****************************************************************
// Capture/compare unit modes
// ****************************************************************
`define PIFR_MODE_OFF        2'h0
`define PIFR_MODE_CAPTURE    2'h1
`define PIFR_MODE_COMPARE    2'h2
`define PIFR_MODE_PWM        2'h3

// ****************************************************************
// Bus responses
// ****************************************************************
`define PIFR_RESP_OKAY       2'h0
`define PIFR_RESP_SLVERR     2'h2

`endif

// File: src/pifr_flags.v
`timescale 1ns/10ps
`default_nettype none
`include "pifr_regs.vh"

// ****************************************************************
// One bank of sticky flags
// ****************************************************************
module pifr_sticky_bank
#(
  parameter [7:0] MASK      = 8'hff,
  parameter [7:0] RESET_VAL = 8'h00
)
(
  // Clock and reset
  input  wire       clk,
  input  wire       reset,
  // Hardware set side
  input  wire [7:0] set_pulse,
  // Software write side
  input  wire       wr_en,
  input  wire [7:0] wr_data,
  // Flag state
  output reg  [7:0] flags_reg
);

  reg [7:0] flags_next;

  // Set wins over a write of 0 in the same cycle
  always @*
  begin
    if (wr_en)
    begin
      flags_next = (set_pulse | wr_data) & MASK;
    end
    else
    begin
      flags_next = (set_pulse | flags_reg) & MASK;
    end
  end

  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      flags_reg <= RESET_VAL;
    end
    else
    begin
      flags_reg <= flags_next;
    end
  end

endmodule

module pifr_flags
#(
  parameter TIMER_W = 16
)
(
  // Clock and reset
  input  wire                 CLK,
  input  wire                 RESET,
  // AXI4-Lite write address
  input  wire [15:0]          S_AXI_AWADDR,
  input  wire [2:0]           S_AXI_AWPROT,
  input  wire                 S_AXI_AWVALID,
  output wire                 S_AXI_AWREADY,
  // AXI4-Lite write data
  input  wire [31:0]          S_AXI_WDATA,
  input  wire [3:0]           S_AXI_WSTRB,
  input  wire                 S_AXI_WVALID,
  output wire                 S_AXI_WREADY,
  // AXI4-Lite write response
  output reg  [1:0]           S_AXI_BRESP,
  output reg                  S_AXI_BVALID,
  input  wire                 S_AXI_BREADY,
  // AXI4-Lite read address
  input  wire [15:0]          S_AXI_ARADDR,
  input  wire [2:0]           S_AXI_ARPROT,
  input  wire                 S_AXI_ARVALID,
  output wire                 S_AXI_ARREADY,
  // AXI4-Lite read data
  output reg  [31:0]          S_AXI_RDATA,
  output reg  [1:0]           S_AXI_RRESP,
  output reg                  S_AXI_RVALID,
  input  wire                 S_AXI_RREADY,
  // Timer 1 period match
  input  wire [TIMER_W-1:0]   TIMER1_COUNT,
  input  wire [TIMER_W-1:0]   TIMER1_PERIOD_VALUE,
  // Timer gate events, bit 0..3 = timer 1,3,5,7
  input  wire [3:0]           GATE_EVENT,
  // Capture/compare units 1..5
  input  wire [9:0]           CAPCOMP_MODE,
  input  wire [4:0]           CAPTURE_EVENT,
  input  wire [4:0]           COMPARE_MATCH_EVENT,
  // System module events
  input  wire                 SCANNER_EVENT,
  input  wire                 CHECKSUM_EVENT,
  input  wire                 NVM_EVENT,
  input  wire                 WAVEFORM_EVENT,
  // Flag outputs
  output wire                 TIMER1_PERIOD_MATCH_FLAG,
  output wire                 TIMER1_GATE_FLAG,
  output wire                 TIMER3_GATE_FLAG,
  output wire                 TIMER5_GATE_FLAG,
  output wire                 TIMER7_GATE_FLAG,
  output wire [4:0]           CAPCOMP_FLAG,
  output wire                 MEMORY_SCANNER_FLAG,
  output wire                 CHECKSUM_ENGINE_FLAG,
  output wire                 NONVOLATILE_MEMORY_FLAG,
  output wire                 WAVEFORM_GENERATOR_FLAG
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  reg  [15:0] awaddr_reg;
  reg         aw_held_reg;
  reg  [7:0]  wdata_reg;
  reg         wstrb0_reg;
  reg         w_held_reg;
  wire        do_write;
  wire [11:0] wr_idx;
  wire        wr_hi_ok;
  wire        wr_hit_period;
  wire        wr_hit_gate;
  wire        wr_hit_capcomp;
  wire        wr_hit_system;
  wire        wr_hit;
  wire        wr_byte;
  wire [11:0] rd_idx;
  wire        rd_hi_ok;
  reg  [7:0]  rd_byte;
  reg         rd_hit;
  wire [7:0]  period_set;
  wire [7:0]  gate_set;
  wire [7:0]  capcomp_set;
  wire [7:0]  system_set;
  wire [4:0]  capcomp_event;
  wire [7:0]  period_flags;
  wire [7:0]  gate_flags;
  wire [7:0]  capcomp_flags;
  wire [7:0]  system_flags;

  // ****************************************************************
  // Write channel: address and data accepted in either order
  // ****************************************************************
  assign S_AXI_AWREADY = ~aw_held_reg;
  assign S_AXI_WREADY  = ~w_held_reg;
  assign do_write      = aw_held_reg & w_held_reg & ~S_AXI_BVALID;

  always @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      awaddr_reg  <= 16'h0000;
      aw_held_reg <= 1'b0;
    end
    else if (S_AXI_AWVALID & ~aw_held_reg)
    begin
      awaddr_reg  <= S_AXI_AWADDR;
      aw_held_reg <= 1'b1;
    end
    else if (do_write)
    begin
      aw_held_reg <= 1'b0;
    end
  end

  always @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      wdata_reg  <= 8'h00;
      wstrb0_reg <= 1'b0;
      w_held_reg <= 1'b0;
    end
    else if (S_AXI_WVALID & ~w_held_reg)
    begin
      wdata_reg  <= S_AXI_WDATA[7:0];
      wstrb0_reg <= S_AXI_WSTRB[0];
      w_held_reg <= 1'b1;
    end
    else if (do_write)
    begin
      w_held_reg <= 1'b0;
    end
  end

  // Register index is the word address
  assign wr_idx         = awaddr_reg[13:2];
  assign wr_hi_ok       = (awaddr_reg[15:14] == 2'h0);
  assign wr_hit_period  = wr_hi_ok & (wr_idx == `PIFR_IDX_PERIOD);
  assign wr_hit_gate    = wr_hi_ok & (wr_idx == `PIFR_IDX_GATE);
  assign wr_hit_capcomp = wr_hi_ok & (wr_idx == `PIFR_IDX_CAPCOMP);
  assign wr_hit_system  = wr_hi_ok & (wr_idx == `PIFR_IDX_SYSTEM);
  assign wr_hit         = wr_hit_period | wr_hit_gate | wr_hit_capcomp | wr_hit_system;
  assign wr_byte        = do_write & wstrb0_reg;

  always @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= `PIFR_RESP_OKAY;
    end
    else if (do_write)
    begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= wr_hit ? `PIFR_RESP_OKAY : `PIFR_RESP_SLVERR;
    end
    else if (S_AXI_BREADY)
    begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // ****************************************************************
  // Read channel: one-cycle answer
  // ****************************************************************
  assign S_AXI_ARREADY = ~S_AXI_RVALID;
  assign rd_idx        = S_AXI_ARADDR[13:2];
  assign rd_hi_ok      = (S_AXI_ARADDR[15:14] == 2'h0);

  always @*
  begin
    rd_byte = 8'h00;
    rd_hit  = rd_hi_ok;
    case (rd_idx)
      `PIFR_IDX_PERIOD:  rd_byte = period_flags;
      `PIFR_IDX_GATE:    rd_byte = gate_flags;
      `PIFR_IDX_CAPCOMP: rd_byte = capcomp_flags;
      `PIFR_IDX_SYSTEM:  rd_byte = system_flags;
      default:           rd_hit  = 1'b0;
    endcase
  end

  always @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h00000000;
      S_AXI_RRESP  <= `PIFR_RESP_OKAY;
    end
    else if (S_AXI_ARVALID & ~S_AXI_RVALID)
    begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA  <= {24'h000000, (rd_hit ? rd_byte : 8'h00)};
      S_AXI_RRESP  <= rd_hit ? `PIFR_RESP_OKAY : `PIFR_RESP_SLVERR;
    end
    else if (S_AXI_RREADY)
    begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // ****************************************************************
  // Set sources
  // ****************************************************************
  assign period_set = {7'h00, (TIMER1_COUNT == TIMER1_PERIOD_VALUE)};
  assign gate_set   = {4'h0, GATE_EVENT};

  genvar u;
  generate
    for (u = 0; u < 5; u = u + 1)
    begin : g_unit
      wire [1:0] mode;
      assign mode = CAPCOMP_MODE[2*u+1:2*u];
      // PWM and off modes never raise the flag
      assign capcomp_event[u] =
        ((mode == `PIFR_MODE_CAPTURE) & CAPTURE_EVENT[u]) |
        ((mode == `PIFR_MODE_COMPARE) & COMPARE_MATCH_EVENT[u]);
    end
  endgenerate

  assign capcomp_set = {3'h0, capcomp_event};

  assign system_set = {SCANNER_EVENT, CHECKSUM_EVENT, NVM_EVENT, 4'h0,
                       WAVEFORM_EVENT};

  // ****************************************************************
  // Flag banks; only reset or a software write lowers a flag
  // ****************************************************************
  pifr_sticky_bank
  #(
    .MASK      (`PIFR_MASK_PERIOD),
    .RESET_VAL (`PIFR_RST_PERIOD)
  )
  u_period
  (
    .clk       (CLK),
    .reset     (RESET),
    .set_pulse (period_set),
    .wr_en     (wr_byte & wr_hit_period),
    .wr_data   (wdata_reg),
    .flags_reg (period_flags)
  );

  pifr_sticky_bank
  #(
    .MASK      (`PIFR_MASK_GATE),
    .RESET_VAL (`PIFR_RST_GATE)
  )
  u_gate
  (
    .clk       (CLK),
    .reset     (RESET),
    .set_pulse (gate_set),
    .wr_en     (wr_byte & wr_hit_gate),
    .wr_data   (wdata_reg),
    .flags_reg (gate_flags)
  );

  pifr_sticky_bank
  #(
    .MASK      (`PIFR_MASK_CAPCOMP),
    .RESET_VAL (`PIFR_RST_CAPCOMP)
  )
  u_capcomp
  (
    .clk       (CLK),
    .reset     (RESET),
    .set_pulse (capcomp_set),
    .wr_en     (wr_byte & wr_hit_capcomp),
    .wr_data   (wdata_reg),
    .flags_reg (capcomp_flags)
  );

  pifr_sticky_bank
  #(
    .MASK      (`PIFR_MASK_SYSTEM),
    .RESET_VAL (`PIFR_RST_SYSTEM)
  )
  u_system
  (
    .clk       (CLK),
    .reset     (RESET),
    .set_pulse (system_set),
    .wr_en     (wr_byte & wr_hit_system),
    .wr_data   (wdata_reg),
    .flags_reg (system_flags)
  );

  // ****************************************************************
  // Flag outputs
  // ****************************************************************
  assign TIMER1_PERIOD_MATCH_FLAG = period_flags[`PIFR_TMR1_PERIOD_BIT];
  assign TIMER1_GATE_FLAG         = gate_flags[`PIFR_GATE_TMR1_BIT];
  assign TIMER3_GATE_FLAG         = gate_flags[`PIFR_GATE_TMR3_BIT];
  assign TIMER5_GATE_FLAG         = gate_flags[`PIFR_GATE_TMR5_BIT];
  assign TIMER7_GATE_FLAG         = gate_flags[`PIFR_GATE_TMR7_BIT];
  assign CAPCOMP_FLAG             = capcomp_flags[4:0];
  assign MEMORY_SCANNER_FLAG      = system_flags[`PIFR_SYS_SCAN_BIT];
  assign CHECKSUM_ENGINE_FLAG     = system_flags[`PIFR_SYS_CHECK_BIT];
  assign NONVOLATILE_MEMORY_FLAG  = system_flags[`PIFR_SYS_NVM_BIT];
  assign WAVEFORM_GENERATOR_FLAG  = system_flags[`PIFR_SYS_WAVE_BIT];

endmodule

`default_nettype wire

// File: testbench/pifr_flags_asserts.sv
`timescale 1ns/10ps
`default_nettype none
`include "pifr_regs.vh"
// ****
// Flag checks
// ****
module pifr_flags_chk
#(
  parameter TIMER_W = 16
)
(
  // Clock and reset
  input wire logic               CLK,
  input wire logic               RESET,
  // Bus
  input wire logic               S_AXI_AWREADY,
  input wire logic               S_AXI_WREADY,
  // Events
  input wire logic [TIMER_W-1:0] TIMER1_COUNT,
  input wire logic [TIMER_W-1:0] TIMER1_PERIOD_VALUE,
  input wire logic [3:0]         GATE_EVENT,
  input wire logic [9:0]         CAPCOMP_MODE,
  input wire logic [4:0]         CAPTURE_EVENT,
  input wire logic [4:0]         COMPARE_MATCH_EVENT,
  input wire logic               NVM_EVENT,
  input wire logic               WAVEFORM_EVENT,
  // Flags
  input wire logic               TIMER1_PERIOD_MATCH_FLAG,
  input wire logic               TIMER1_GATE_FLAG,
  input wire logic [4:0]         CAPCOMP_FLAG,
  input wire logic               CHECKSUM_ENGINE_FLAG,
  input wire logic               NONVOLATILE_MEMORY_FLAG,
  input wire logic               WAVEFORM_GENERATOR_FLAG
);
  // Both channels held: a write lands at the next edge with S_AXI_BVALID low
  wire wr_hold = !S_AXI_AWREADY && !S_AXI_WREADY;
  wire wave_cause = wr_hold || WAVEFORM_EVENT;
  wire pwm1 = CAPCOMP_MODE[3:2] == `PIFR_MODE_PWM;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);
  AST_PERIOD_SET: assert property (
    TIMER1_COUNT == TIMER1_PERIOD_VALUE |=> TIMER1_PERIOD_MATCH_FLAG)
    else $error("period flag missed");
  AST_GATE_SET: assert property (GATE_EVENT[0] |=> TIMER1_GATE_FLAG)
    else $error("gate flag missed");
  AST_CAPT_SET: assert property (
    CAPCOMP_MODE[1:0] == `PIFR_MODE_CAPTURE && CAPTURE_EVENT[0] |=> CAPCOMP_FLAG[0])
    else $error("capture flag missed");
  AST_CMP_SET: assert property (
    CAPCOMP_MODE[9:8] == `PIFR_MODE_COMPARE && COMPARE_MATCH_EVENT[4] |=> CAPCOMP_FLAG[4])
    else $error("compare flag missed");
  AST_PWM_QUIET: assert property (
    pwm1 && !wr_hold && !CAPCOMP_FLAG[1] |=> !CAPCOMP_FLAG[1])
    else $error("flag set in pwm mode");
  AST_WAVE_QUIET: assert property (
    $rose(WAVEFORM_GENERATOR_FLAG) |-> $past(wave_cause))
    else $error("waveform flag set without cause");
  AST_CHECK_HOLD: assert property (
    CHECKSUM_ENGINE_FLAG && !wr_hold |=> CHECKSUM_ENGINE_FLAG)
    else $error("checksum flag dropped");
  AST_NVM_SET: assert property (NVM_EVENT |=> NONVOLATILE_MEMORY_FLAG)
    else $error("memory flag lost");
  cover property ($rose(CAPCOMP_FLAG[0]));
  cover property ($rose(TIMER1_PERIOD_MATCH_FLAG));
  cover property (wr_hold ##1 $fell(CHECKSUM_ENGINE_FLAG));
endmodule

bind pifr_flags pifr_flags_chk #(.TIMER_W(TIMER_W)) i_chk (
  .CLK(CLK), .RESET(RESET), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WREADY(S_AXI_WREADY),
  .TIMER1_COUNT(TIMER1_COUNT), .TIMER1_PERIOD_VALUE(TIMER1_PERIOD_VALUE),
  .GATE_EVENT(GATE_EVENT), .CAPCOMP_MODE(CAPCOMP_MODE), .CAPTURE_EVENT(CAPTURE_EVENT),
  .COMPARE_MATCH_EVENT(COMPARE_MATCH_EVENT), .NVM_EVENT(NVM_EVENT),
  .WAVEFORM_EVENT(WAVEFORM_EVENT), .TIMER1_PERIOD_MATCH_FLAG(TIMER1_PERIOD_MATCH_FLAG),
  .TIMER1_GATE_FLAG(TIMER1_GATE_FLAG), .CAPCOMP_FLAG(CAPCOMP_FLAG),
  .CHECKSUM_ENGINE_FLAG(CHECKSUM_ENGINE_FLAG),
  .NONVOLATILE_MEMORY_FLAG(NONVOLATILE_MEMORY_FLAG),
  .WAVEFORM_GENERATOR_FLAG(WAVEFORM_GENERATOR_FLAG));
`default_nettype wire

// File: testbench/pifr_periph_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Peripheral event sources
// ****
module pifr_periph_model
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Requests
  input  wire logic [17:0] ev_req,
  input  wire logic        run,
  // Events
  output var  logic [17:0] ev,
  output var  logic [15:0] cnt
);
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ev  <= 18'h0;
      cnt <= 16'h0;
    end
    else
    begin
      ev  <= ev_req;
      cnt <= run ? cnt + 16'h1 : 16'h0;
    end
  end
endmodule
`default_nettype wire

// File: testbench/tb_peripheral_irq_flag_regs.sv
`timescale 1ns/10ps
`default_nettype none
`include "pifr_regs.vh"
module tb_peripheral_irq_flag_regs;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic [15:0] adr = 16'h0;
  logic [31:0] wd = 32'h0;
  logic [3:0]  ws = 4'h0;
  logic        awv = 1'h0;
  logic        wv = 1'h0;
  logic        bre = 1'h0;
  logic        arv = 1'h0;
  logic        rre = 1'h0;
  logic [9:0]  mode = 10'h0;
  logic [17:0] ev_req = 18'h0;
  logic        run = 1'h0;
  logic [15:0] per = 16'h5;
  logic [31:0] seed = 32'hf062;
  logic [31:0] q;
  logic [1:0]  r;
  wire         awr, wr, arr, bv, rv;
  wire  [1:0]  br, rr;
  wire  [31:0] rd;
  wire  [17:0] ev;
  wire  [15:0] cnt;
  wire  [13:0] fl;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          k;
  int          ex[4];
  int          msk[4] = '{`PIFR_MASK_PERIOD, `PIFR_MASK_GATE, `PIFR_MASK_CAPCOMP, `PIFR_MASK_SYSTEM};

  always #2.5 clk = ~clk;
  pifr_periph_model i_model (.clk(clk), .reset(rst), .ev_req(ev_req), .run(run), .ev(ev),
    .cnt(cnt));
  pifr_flags i_dut (
    .CLK(clk), .RESET(rst), .S_AXI_AWADDR(adr), .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wr), .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bre),
    .S_AXI_ARADDR(adr), .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rd), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rre),
    .TIMER1_COUNT(cnt), .TIMER1_PERIOD_VALUE(per), .GATE_EVENT(ev[3:0]),
    .CAPCOMP_MODE(mode), .CAPTURE_EVENT(ev[8:4]), .COMPARE_MATCH_EVENT(ev[13:9]),
    .SCANNER_EVENT(ev[17]), .CHECKSUM_EVENT(ev[16]), .NVM_EVENT(ev[15]),
    .WAVEFORM_EVENT(ev[14]), .TIMER1_PERIOD_MATCH_FLAG(fl[0]), .TIMER1_GATE_FLAG(fl[1]),
    .TIMER3_GATE_FLAG(fl[2]), .TIMER5_GATE_FLAG(fl[3]), .TIMER7_GATE_FLAG(fl[4]),
    .CAPCOMP_FLAG(fl[9:5]), .WAVEFORM_GENERATOR_FLAG(fl[10]),
    .NONVOLATILE_MEMORY_FLAG(fl[11]), .CHECKSUM_ENGINE_FLAG(fl[12]),
    .MEMORY_SCANNER_FLAG(fl[13]));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    total_checks++;
    if (got !== want)
    begin
      n_mismatch++;
      $display("MISMATCH at %0t: got %h want %h", $time, got, want);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // One bus transfer; read data and response land in q and r
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d, input logic s);
    int n;
    // Let an edge pass so no request signal is driven twice in one step
    @(posedge clk);
    adr <= {2'h0, a, 2'h0};
    wd <= {24'h0, d};
    ws <= {3'h0, s};
    awv <= w;
    wv <= w;
    bre <= w;
    arv <= !w;
    rre <= !w;
    for (n = 0; n < 40 && !(bre && bv || rre && rv); n++)
    begin
      @(posedge clk);
      if (awr)
        awv <= 1'h0;
      if (wr)
        wv <= 1'h0;
      if (arr)
        arv <= 1'h0;
    end
    q = rd;
    r = w ? br : rr;
    bre <= 1'h0;
    rre <= 1'h0;
    chk(n < 40, 1'h1);
    if (n == 40)
      report_and_stop();
  endtask

  task automatic allchk();
    for (int i = 0; i < 4; i++)
    begin
      bus(1'h0, `PIFR_IDX_PERIOD + 12'(i), 8'h0, 1'h0);
      chk(q, ex[i]);
      chk(r, `PIFR_RESP_OKAY);
    end
    chk(fl, {ex[3][7:5], ex[3][0], ex[2][4:0], ex[1][3:0], ex[0][0]});
  endtask

  task automatic wrc(input int i, input logic [7:0] d, input logic s);
    bus(1'h1, `PIFR_IDX_PERIOD + 12'(i), d, s);
    chk(r, `PIFR_RESP_OKAY);
    if (s)
      ex[i] = d & msk[i];
  endtask

  task automatic fire(input logic [17:0] v, input logic [9:0] m);
    mode <= m;
    ev_req <= v;
    @(posedge clk);
    ev_req <= 18'h0;
    repeat (2) @(posedge clk);
    ex[1] |= v[3:0];
    ex[3] |= {v[17:15], 4'h0, v[14]};
    for (int u = 0; u < 5; u++)
      if (m[2*u+:2] == `PIFR_MODE_CAPTURE && v[4+u] || m[2*u+:2] == `PIFR_MODE_COMPARE && v[9+u])
        ex[2] |= 1 << u;
  endtask

  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    allchk();
    bus(1'h1, 12'he40, 8'hff, 1'h1);
    chk(r, `PIFR_RESP_SLVERR);
    bus(1'h0, 12'he40, 8'h0, 1'h0);
    chk(q, 32'h0);
    chk(r, `PIFR_RESP_SLVERR);
    for (k = 0; k < 40; k++)
    begin
      fire(18'(rnd() & rnd()), 10'(rnd()));
      allchk();
      wrc(k % 4, 8'(rnd()), rnd() % 3 != 0);
      allchk();
    end
    // Count runs 1..8 past the compare; a period above 8 is never reached
    per <= 16'(1 + rnd() % 16);
    run <= 1'h1;
    repeat (8) @(posedge clk);
    run <= 1'h0;
    repeat (2) @(posedge clk);
    if (per <= 16'h8)
      ex[0] = 1;
    allchk();
    ev_req <= 18'h3ffff;
    mode <= 10'h255;
    for (k = 0; k < 4; k++)
      wrc(k, 8'h0, 1'h1);
    ex = msk;
    ex[0] = 0;
    allchk();
    ev_req <= 18'h0;
    repeat (3) @(posedge clk);
    for (k = 0; k < 4; k++)
      wrc(k, 8'h0, 1'h1);
    allchk();
    // Mid-run reset with every flag but the period match set must clear them all
    fire(18'h3ffff, 10'h2aa);
    allchk();
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    ex = '{0, 0, 0, 0};
    allchk();
    report_and_stop();
  end
endmodule
`default_nettype wire
